// ### hw/fbd_decoder.sv
// function button push decoder: press, single and double push with wishbone registers
`timescale 1ns/1ps
`include "fbd_defines.svh"

// Contract
// (RULE1) clockwise held press issues cw press action
// (RULE2) ccw held press issues ccw press action
// (RULE3) clockwise single push issues its action
// (RULE4) ccw single push issues its action
// (RULE5) clockwise double push issues its action
// (RULE6) ccw double push issues its action
// (RULE7) push needs release within detect interval
// (RULE8) further push only inside next-push window
// (RULE9) press outlasting detect interval is held press
// (RULE10) single reported after window; second gives double
module fbd_decoder #(
    parameter bit TOGGLE_VARIANT = 1'b0,          // drive variant with toggle default
    parameter int MS_CYCLES      = `FBD_MS_CYCLES // cycles per millisecond
) (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        NRST,
    // operator inputs
    input  wire logic        BUTTON,   // high while pressed
    input  wire logic        RING_CW,  // high in cw, low in ccw
    // action request to tool controller
    output logic             ACT_REQ,   // one-cycle pulse
    output logic [7:0]       ACT_CODE,
    output logic [2:0]       ACT_EVENT,
    // wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic [31:0]      WB_DAT_O,
    output logic             WB_ACK_O,
    // interrupt
    output logic             IRQ
);

    localparam logic [7:0] ACT_RST = TOGGLE_VARIANT ? `FBD_CODE_TOGGLE : `FBD_CODE_OFF;

    // ----------------------------------------------------------------------
    // state
    // ----------------------------------------------------------------------
    fbd_pkg::fbd_state_t  st_r, st_nxt;             // decoder state
    logic                 ccw_r, ccw_nxt;           // ring position at first press
    logic                 en_r, en_nxt;             // decoder enable
    logic [5:0]           sts_r, sts_nxt;           // sticky event bits
    logic [5:0]           msk_r, msk_nxt;           // interrupt mask
    logic [7:0]           act_r   [6];              // action code per event
    logic [7:0]           act_nxt [6];
    logic [9:0]           pdi_r, pdi_nxt;           // push detect interval, ms
    logic [9:0]           npi_r, npi_nxt;           // next push interval, ms
    logic [7:0]           last_r, last_nxt;         // last issued code
    fbd_pkg::fbd_event_t  lev_r, lev_nxt;           // last event index
    logic                 req_r, req_nxt;
    logic [7:0]           code_r, code_nxt;
    fbd_pkg::fbd_event_t  evo_r, evo_nxt;
    logic [31:0]          dat_r, dat_nxt;
    logic                 ack_r, ack_nxt;
    logic                 irq_r, irq_nxt;

    // decoder combinational results
    logic                 ev_valid;                 // event this cycle
    fbd_pkg::fbd_event_t  ev_idx;
    logic                 t_start;
    logic [9:0]           t_limit;

    fbd_tmr_if tmr ();

    fbd_timer #(.MS_CYCLES(MS_CYCLES)) u_timer (
        .clk  (CLK),
        .nrst (NRST),
        .t    (tmr)
    );

    assign tmr.start = t_start;
    assign tmr.limit = t_limit;

    // ----------------------------------------------------------------------
    // push decoder
    // ----------------------------------------------------------------------
    // release is looked at before expiry, so a release in the very cycle the
    // window runs out still counts as inside the window
    always_comb begin
        st_nxt   = st_r;
        ccw_nxt  = ccw_r;
        ev_valid = 1'b0;
        ev_idx   = 3'h0;
        t_start  = 1'b0;
        t_limit  = pdi_r;
        case (st_r)
            fbd_pkg::ST_IDLE: begin
                if (en_r && BUTTON) begin
                    ccw_nxt = !RING_CW;
                    t_start = 1'b1;
                    st_nxt  = fbd_pkg::ST_DOWN1;
                end
            end
            fbd_pkg::ST_DOWN1: begin
                if (!BUTTON) begin
                    // released in time: a push, open the gap window
                    t_start = 1'b1;                  // see RULE7
                    t_limit = npi_r;                 // see RULE8
                    st_nxt  = fbd_pkg::ST_GAP;
                end else if (tmr.expired) begin
                    ev_valid = 1'b1;                 // see RULE9
                    ev_idx   = {2'b00, ccw_r};       // see RULE1 / see RULE2
                    st_nxt   = fbd_pkg::ST_HELD;
                end
            end
            fbd_pkg::ST_GAP: begin
                if (BUTTON) begin
                    t_start = 1'b1;                  // see RULE8
                    st_nxt  = fbd_pkg::ST_DOWN2;
                end else if (tmr.expired) begin
                    ev_valid = 1'b1;                 // see RULE10
                    ev_idx   = {2'b01, ccw_r};       // see RULE3 / see RULE4
                    st_nxt   = fbd_pkg::ST_IDLE;
                end
            end
            fbd_pkg::ST_DOWN2: begin
                if (!BUTTON) begin
                    ev_valid = 1'b1;                 // see RULE10
                    ev_idx   = {2'b10, ccw_r};       // see RULE5 / see RULE6
                    st_nxt   = fbd_pkg::ST_IDLE;
                end else if (tmr.expired) begin
                    // second press held too long: the first push is dropped
                    ev_valid = 1'b1;                 // see RULE9
                    ev_idx   = {2'b00, ccw_r};
                    st_nxt   = fbd_pkg::ST_HELD;
                end
            end
            fbd_pkg::ST_HELD: begin
                // one action per hold; wait for the release
                if (!BUTTON) begin
                    st_nxt = fbd_pkg::ST_IDLE;
                end
            end
            default: begin
                st_nxt = fbd_pkg::ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------------
    // registers, bus and outputs: next values
    // ----------------------------------------------------------------------
    logic        acc;       // request seen, answer pending
    logic        wr;        // write takes effect this edge
    logic [31:0] wm;        // byte lane mask
    logic [31:0] wd;        // masked write data
    logic [9:0]  pdi_w;
    logic [9:0]  npi_w;

    // clamp a written interval into the legal range
    function automatic logic [9:0] clamp_ms(input logic [9:0] v);
        if (v < `FBD_INTERVAL_MIN) begin
            return `FBD_INTERVAL_MIN;
        end else if (v > `FBD_INTERVAL_MAX) begin
            return `FBD_INTERVAL_MAX;
        end
        return v;
    endfunction

    always_comb begin
        acc      = WB_CYC_I && WB_STB_I && !ack_r;
        wr       = WB_CYC_I && WB_STB_I && ack_r && WB_WE_I;
        wm       = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
        wd       = WB_DAT_I & wm;
        en_nxt   = en_r;
        msk_nxt  = msk_r;
        pdi_nxt  = pdi_r;
        npi_nxt  = npi_r;
        for (int i = 0; i < 6; i++) begin
            act_nxt[i] = act_r[i];
        end
        pdi_w    = (pdi_r & ~wm[9:0]) | wd[9:0];
        npi_w    = (npi_r & ~wm[25:16]) | wd[25:16];
        sts_nxt  = sts_r;
        // software writes happen at the edge the master sees ack
        if (wr) begin
            case (WB_ADR_I)
                `FBD_OFF_CTRL:       en_nxt  = (en_r & ~wm[0]) | wd[0];
                `FBD_OFF_STATUS:     sts_nxt = sts_r & ~wd[5:0];
                `FBD_OFF_MASK:       msk_nxt = (msk_r & ~wm[5:0]) | wd[5:0];
                `FBD_OFF_ACT_PRESS: begin
                    act_nxt[0] = (act_r[0] & ~wm[7:0])  | wd[7:0];
                    act_nxt[1] = (act_r[1] & ~wm[15:8]) | wd[15:8];
                end
                `FBD_OFF_ACT_SINGLE: begin
                    act_nxt[2] = (act_r[2] & ~wm[7:0])  | wd[7:0];
                    act_nxt[3] = (act_r[3] & ~wm[15:8]) | wd[15:8];
                end
                `FBD_OFF_ACT_DOUBLE: begin
                    act_nxt[4] = (act_r[4] & ~wm[7:0])  | wd[7:0];
                    act_nxt[5] = (act_r[5] & ~wm[15:8]) | wd[15:8];
                end
                `FBD_OFF_INTERVALS: begin
                    pdi_nxt = clamp_ms(pdi_w);
                    npi_nxt = clamp_ms(npi_w);
                end
                default: begin
                    // unmapped or read-only: write ignored
                end
            endcase
        end
        // hardware set wins over a software clear in the same cycle
        if (ev_valid) begin
            sts_nxt[ev_idx] = 1'b1;
        end
        // request only for a configured code; off means no action
        req_nxt   = ev_valid && (act_r[ev_idx] != `FBD_CODE_OFF);
        code_nxt  = ev_valid ? act_r[ev_idx] : code_r;
        evo_nxt   = ev_valid ? ev_idx : evo_r;
        last_nxt  = req_nxt ? act_r[ev_idx] : last_r;
        lev_nxt   = ev_valid ? ev_idx : lev_r;
        irq_nxt   = |(sts_nxt & msk_nxt);
        ack_nxt   = acc;
        dat_nxt   = 32'h00000000;
        if (acc && !WB_WE_I) begin
            case (WB_ADR_I)
                `FBD_OFF_CTRL:       dat_nxt = {31'h0, en_r};
                `FBD_OFF_STATUS:     dat_nxt = {26'h0, sts_r};
                `FBD_OFF_MASK:       dat_nxt = {26'h0, msk_r};
                `FBD_OFF_ACT_PRESS:  dat_nxt = {16'h0, act_r[1], act_r[0]};
                `FBD_OFF_ACT_SINGLE: dat_nxt = {16'h0, act_r[3], act_r[2]};
                `FBD_OFF_ACT_DOUBLE: dat_nxt = {16'h0, act_r[5], act_r[4]};
                `FBD_OFF_INTERVALS:  dat_nxt = {6'h0, npi_r, 6'h0, pdi_r};
                `FBD_OFF_LAST:       dat_nxt = {21'h0, lev_r, last_r};
                default:             dat_nxt = 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // register stage
    // ----------------------------------------------------------------------
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            st_r   <= fbd_pkg::ST_IDLE;
            ccw_r  <= 1'b0;
            en_r   <= `FBD_CTRL_RST;
            sts_r  <= 6'h00;
            msk_r  <= `FBD_MASK_RST;
            act_r[0] <= ACT_RST;                         // see RULE1
            act_r[1] <= ACT_RST;                         // see RULE2
            for (int i = 2; i < 6; i++) begin
                act_r[i] <= `FBD_CODE_OFF;
            end
            pdi_r  <= `FBD_INTERVAL_RST;                 // see RULE7
            npi_r  <= `FBD_INTERVAL_RST;                 // see RULE8
            last_r <= 8'h00;
            lev_r  <= 3'h0;
            req_r  <= 1'b0;
            code_r <= 8'h00;
            evo_r  <= 3'h0;
            dat_r  <= 32'h00000000;
            ack_r  <= 1'b0;
            irq_r  <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            ccw_r  <= ccw_nxt;
            en_r   <= en_nxt;
            sts_r  <= sts_nxt;
            msk_r  <= msk_nxt;
            act_r  <= act_nxt;
            pdi_r  <= pdi_nxt;
            npi_r  <= npi_nxt;
            last_r <= last_nxt;
            lev_r  <= lev_nxt;
            req_r  <= req_nxt;
            code_r <= code_nxt;
            evo_r  <= evo_nxt;
            dat_r  <= dat_nxt;
            ack_r  <= ack_nxt;
            irq_r  <= irq_nxt;
        end
    end

    assign ACT_REQ   = req_r;
    assign ACT_CODE  = code_r;
    assign ACT_EVENT = evo_r;
    assign WB_DAT_O  = dat_r;
    assign WB_ACK_O  = ack_r;
    assign IRQ       = irq_r;

    // ----------------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------------
    property p_cw_press;
        @(posedge CLK) disable iff (!NRST)
        (st_r == fbd_pkg::ST_DOWN1 && BUTTON && tmr.expired && !ccw_r)
        |=> sts_r[0] && st_r == fbd_pkg::ST_HELD && evo_r == 3'h0;
    endproperty
    a_cw_press: assert property (p_cw_press) else $error("cw press lost"); // see RULE1

    property p_ccw_press;
        @(posedge CLK) disable iff (!NRST)
        (st_r == fbd_pkg::ST_DOWN1 && BUTTON && tmr.expired && ccw_r)
        |=> sts_r[1] && evo_r == 3'h1;
    endproperty
    a_ccw_press: assert property (p_ccw_press) else $error("ccw press lost"); // see RULE2

    property p_cw_single;
        @(posedge CLK) disable iff (!NRST)
        (st_r == fbd_pkg::ST_GAP && !BUTTON && tmr.expired && !ccw_r)
        |=> sts_r[2] && st_r == fbd_pkg::ST_IDLE;
    endproperty
    a_cw_single: assert property (p_cw_single) else $error("cw single lost"); // see RULE3

    property p_ccw_single;
        @(posedge CLK) disable iff (!NRST)
        (st_r == fbd_pkg::ST_GAP && !BUTTON && tmr.expired && ccw_r) |=> sts_r[3];
    endproperty
    a_ccw_single: assert property (p_ccw_single) else $error("ccw single lost"); // see RULE4

    property p_cw_double;
        @(posedge CLK) disable iff (!NRST)
        (st_r == fbd_pkg::ST_DOWN2 && !BUTTON && !ccw_r) |=> sts_r[4] && evo_r == 3'h4;
    endproperty
    a_cw_double: assert property (p_cw_double) else $error("cw double lost"); // see RULE5

    property p_ccw_double;
        @(posedge CLK) disable iff (!NRST)
        (st_r == fbd_pkg::ST_DOWN2 && !BUTTON && ccw_r) |=> sts_r[5] && evo_r == 3'h5;
    endproperty
    a_ccw_double: assert property (p_ccw_double) else $error("ccw double lost"); // see RULE6

    property p_push_release;
        @(posedge CLK) disable iff (!NRST)
        (st_r == fbd_pkg::ST_DOWN1 && !BUTTON) |=> st_r == fbd_pkg::ST_GAP && !ACT_REQ;
    endproperty
    a_push_release: assert property (p_push_release) else $error("push not seen"); // see RULE7

    property p_gap_press;
        @(posedge CLK) disable iff (!NRST)
        (st_r == fbd_pkg::ST_GAP && BUTTON) |=> st_r == fbd_pkg::ST_DOWN2 && !tmr.expired;
    endproperty
    a_gap_press: assert property (p_gap_press) else $error("second push missed"); // see RULE8

    property p_held_stays;
        @(posedge CLK) disable iff (!NRST)
        (st_r == fbd_pkg::ST_HELD && BUTTON) |=> st_r == fbd_pkg::ST_HELD && !ACT_REQ;
    endproperty
    a_held_stays: assert property (p_held_stays) else $error("held press repeated"); // see RULE9

    property p_no_early_single;
        @(posedge CLK) disable iff (!NRST)
        (st_r == fbd_pkg::ST_GAP && !tmr.expired) |=> !$rose(sts_r[2]) && !$rose(sts_r[3]);
    endproperty
    a_no_early_single: assert property (p_no_early_single) else $error("early single"); // see RULE10

    property p_req_code;
        @(posedge CLK) disable iff (!NRST)
        (ev_valid && act_r[ev_idx] != 8'h00) |=> ACT_REQ && ACT_CODE == $past(act_r[ev_idx]);
    endproperty
    a_req_code: assert property (p_req_code) else $error("wrong action code"); // see RULE1

endmodule // fbd_decoder

// ### hw/fbd_defines.svh
// constants of the function button push decoder: offsets, fields, resets, timing
`ifndef FBD_DEFINES_SVH
`define FBD_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define FBD_OFF_CTRL       8'h00
`define FBD_OFF_STATUS     8'h04
`define FBD_OFF_MASK       8'h08
`define FBD_OFF_ACT_PRESS  8'h0c
`define FBD_OFF_ACT_SINGLE 8'h10
`define FBD_OFF_ACT_DOUBLE 8'h14
`define FBD_OFF_INTERVALS  8'h18
`define FBD_OFF_LAST       8'h1c

// ----------------------------------------------------------------------
// field layout
// ----------------------------------------------------------------------
`define FBD_EV_N           6
`define FBD_CODE_W         8
`define FBD_MS_W           10
`define FBD_NEXT_LSB       16
`define FBD_LAST_EV_LSB    8

// ----------------------------------------------------------------------
// reset values and code points
// ----------------------------------------------------------------------
`define FBD_CODE_OFF       8'h00
`define FBD_CODE_TOGGLE    8'h61
`define FBD_CTRL_RST       1'b1
`define FBD_MASK_RST       6'h00

// ----------------------------------------------------------------------
// timing, in milliseconds and clock cycles
// ----------------------------------------------------------------------
`define FBD_INTERVAL_MIN   10'h0fa
`define FBD_INTERVAL_MAX   10'h3e8
`define FBD_INTERVAL_RST   10'h12c
`define FBD_CLK_MHZ        100
`define FBD_MS_CYCLES      (`FBD_CLK_MHZ * 1000)

`endif

// ### hw/fbd_pkg.sv
// types of the function button push decoder
package fbd_pkg;

    // decoder states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DOWN1,
        ST_GAP,
        ST_DOWN2,
        ST_HELD
    } fbd_state_t;

    // event index: class times two plus one for counter-clockwise
    typedef logic [2:0] fbd_event_t;

endpackage

// ### hw/fbd_timer.sv
// millisecond interval timer used for both the push and the gap windows
`timescale 1ns/1ps
`include "fbd_defines.svh"

module fbd_timer #(
    parameter int MS_CYCLES = `FBD_MS_CYCLES
) (
    // clock and reset
    input  wire logic   clk,
    input  wire logic   nrst,
    // control
    fbd_tmr_if.tmr      t
);

    logic [16:0]          pre_r, pre_nxt;   // cycles inside the current ms
    logic [`FBD_MS_W-1:0] ms_r, ms_nxt;     // whole ms elapsed
    logic [`FBD_MS_W-1:0] lim_r, lim_nxt;   // latched limit
    logic                 exp_r, exp_nxt;   // expiry level

    // ----------------------------------------------------------------------
    // next values: prescaler first, ms count stops once expired
    // ----------------------------------------------------------------------
    always_comb begin
        pre_nxt = pre_r;
        ms_nxt  = ms_r;
        lim_nxt = lim_r;
        exp_nxt = exp_r;
        if (t.start) begin
            // restart: prescaler phase reset so the window is exact
            pre_nxt = 17'h00000;
            ms_nxt  = 10'h000;
            lim_nxt = t.limit;
            exp_nxt = 1'b0;
        end else if (!exp_r) begin
            if (pre_r == 17'(MS_CYCLES - 1)) begin
                pre_nxt = 17'h00000;
                ms_nxt  = ms_r + 10'h001;
                if (ms_r + 10'h001 >= lim_r) begin
                    exp_nxt = 1'b1;
                end
            end else begin
                pre_nxt = pre_r + 17'h00001;
            end
        end
    end

    // registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pre_r <= 17'h00000;
            ms_r  <= 10'h000;
            lim_r <= `FBD_INTERVAL_RST;
            exp_r <= 1'b1;
        end else begin
            pre_r <= pre_nxt;
            ms_r  <= ms_nxt;
            lim_r <= lim_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign t.expired = exp_r;

endmodule // fbd_timer

// ### hw/fbd_tmr_if.sv
// carrier between the decoder and its millisecond interval timer
`timescale 1ns/1ps
interface fbd_tmr_if;
    logic       start;     // restart pulse, loads limit
    logic [9:0] limit;     // interval in ms, taken at start
    logic       expired;   // level, high once limit ms have passed

    modport ctl (output start, output limit, input expired);
    modport tmr (input start, input limit, output expired);
endinterface

// ### test/fbd_operator.sv
// operator model: function button and direction ring in front of the decoder
`timescale 1ns/1ps
module fbd_operator (
    // clock
    input  wire logic clk,
    // operator pins
    output logic      button,   // high while pressed
    output logic      ring_cw   // high in clockwise position
);
    // idle operator: button released, ring clockwise
    initial begin
        button  = 1'b0;
        ring_cw = 1'b1;
    end

    // ------------------------------------------------------------
    // gesture: press h1 cycles, then if h2 > 0 a gap g and a second press
    // ------------------------------------------------------------
    // ring is set together with the first press, as a hand would do it
    task automatic gesture(input int h1, input int g, input int h2, input logic cw);
        @(posedge clk);
        ring_cw <= cw;
        button  <= 1'b1;
        repeat (h1) @(posedge clk);
        button <= 1'b0;
        if (h2 > 0) begin
            repeat (g) @(posedge clk);
            button <= 1'b1;
            repeat (h2) @(posedge clk);
            button <= 1'b0;
        end
    endtask
endmodule // fbd_operator

// ### test/testbench.sv
// self-checking bench of the function button push decoder
`timescale 1ns/1ps
`define CHECK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module testbench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        CLK, NRST, BUTTON, RING_CW;  // clock, reset, operator pins
    logic        ACT_REQ, WB_ACK_O, IRQ;      // design outputs
    logic [7:0]  ACT_CODE;
    logic [2:0]  ACT_EVENT;
    logic [31:0] WB_DAT_O;
    logic        cyc, stb, we;                // bus master side
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat, rd;
    logic [7:0]  codes [6];                   // expected code per event index
    int          miscompares, n_tests;

    // one cycle is one millisecond so the 250 ms windows last 250 cycles
    fbd_decoder #(.TOGGLE_VARIANT(1'b1), .MS_CYCLES(1)) dut (.CLK(CLK), .NRST(NRST),
        .BUTTON(BUTTON), .RING_CW(RING_CW), .ACT_REQ(ACT_REQ), .ACT_CODE(ACT_CODE),
        .ACT_EVENT(ACT_EVENT), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(WB_DAT_O),
        .WB_ACK_O(WB_ACK_O), .IRQ(IRQ));
    fbd_operator op (.clk(CLK), .button(BUTTON), .ring_cw(RING_CW));

    // 100 MHz clock
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    // ------------------------------------------------------------
    // bus cycle: hold the request until ack is sampled, then release
    // ------------------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge CLK);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        // a missing answer is left to the watchdog
        do begin
            @(posedge CLK);
        end while (WB_ACK_O !== 1'b1);
        q = WB_DAT_O;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    // one gesture, then the action must come within [lo, hi] cycles of the press
    task automatic do_ev(input int h1, input int g, input int h2, input logic cw,
                         input logic [2:0] ev, input int lo, input int hi);
        int n;
        n = 0;
        fork
            op.gesture(h1, g, h2, cw);
            begin
                while (n < 800 && ACT_REQ !== 1'b1) begin
                    @(posedge CLK);
                    n++;
                end
                @(posedge CLK);
                `CHECK("act_req_pulse", 1'b0, ACT_REQ)
            end
        join
        `CHECK("act_event", ev, ACT_EVENT)
        `CHECK("act_code", codes[ev], ACT_CODE)
        `CHECK("event_time", 1'b1, (n >= lo && n <= hi))
        repeat (300) @(posedge CLK);  // let every window run out
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // reset values, unmapped read, then codes and clamped intervals
    task automatic t_regs();
        wb(1'b0, 8'h00, 32'h0, rd); `CHECK("ctrl", 32'h00000001, rd)
        wb(1'b0, 8'h08, 32'h0, rd); `CHECK("mask", 32'h00000000, rd)
        wb(1'b0, 8'h0c, 32'h0, rd); `CHECK("press", 32'h00006161, rd)
        wb(1'b0, 8'h10, 32'h0, rd); `CHECK("single", 32'h00000000, rd)
        wb(1'b0, 8'h14, 32'h0, rd); `CHECK("double", 32'h00000000, rd)
        wb(1'b0, 8'h18, 32'h0, rd); `CHECK("intv", 32'h012c012c, rd)
        wb(1'b0, 8'h20, 32'h0, rd); `CHECK("unmapped", 32'h00000000, rd)
        wb(1'b1, 8'h18, 32'h03ff03ff, rd);
        wb(1'b0, 8'h18, 32'h0, rd); `CHECK("intv_hi", 32'h03e803e8, rd)
        wb(1'b1, 8'h18, 32'h00000000, rd);
        wb(1'b0, 8'h18, 32'h0, rd); `CHECK("intv_lo", 32'h00fa00fa, rd)
        wb(1'b1, 8'h0c, 32'h00002261, rd);
        wb(1'b1, 8'h10, 32'h00003433, rd);
        wb(1'b1, 8'h14, 32'h00004645, rd);
    endtask

    // sticky status, masked level interrupt, write-one-to-clear
    task automatic t_irq();
        wb(1'b0, 8'h04, 32'h0, rd); `CHECK("status", 32'h0000003f, rd)
        `CHECK("irq_masked", 1'b0, IRQ)
        wb(1'b0, 8'h1c, 32'h0, rd); `CHECK("last", 32'h00000546, rd)
        wb(1'b1, 8'h08, 32'h00000004, rd);
        repeat (2) @(posedge CLK);
        `CHECK("irq_on", 1'b1, IRQ)
        wb(1'b1, 8'h04, 32'h00000004, rd);
        repeat (2) @(posedge CLK);
        `CHECK("irq_off", 1'b0, IRQ)
        wb(1'b0, 8'h04, 32'h0, rd); `CHECK("status_w1c", 32'h0000003b, rd)
    endtask

    // disabled decoder ignores presses; an off code sets status, asks nothing
    task automatic t_quiet();
        int n;
        n = 0;
        wb(1'b1, 8'h00, 32'h00000000, rd);
        fork
            op.gesture(300, 0, 0, 1'b1);
            repeat (600) begin
                @(posedge CLK);
                if (ACT_REQ === 1'b1) n++;
            end
        join
        wb(1'b0, 8'h04, 32'h0, rd); `CHECK("status_off", 32'h0000003b, rd)
        wb(1'b1, 8'h00, 32'h00000001, rd);
        wb(1'b1, 8'h10, 32'h00003400, rd);
        fork
            op.gesture(100, 0, 0, 1'b1);
            repeat (600) begin
                @(posedge CLK);
                if (ACT_REQ === 1'b1) n++;
            end
        join
        `CHECK("req_none", 0, n)
        wb(1'b0, 8'h04, 32'h0, rd); `CHECK("status_quiet", 32'h0000003f, rd)
        `CHECK("irq_quiet", 1'b1, IRQ)
    endtask

    // verdict, reached from the main sequence or the watchdog
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // watchdog: the run needs some 5000 cycles
    initial begin
        #500000;
        miscompares++;
        close_out();
    end

    // main sequence
    initial begin
        {NRST, cyc, stb, we, adr, sel, dat} = '0;
        codes = '{8'h61, 8'h22, 8'h33, 8'h34, 8'h45, 8'h46};
        miscompares = 0;
        n_tests = 0;
        repeat (5) @(posedge CLK);
        NRST <= 1'b1;
        t_regs();
        do_ev(300, 0, 0, 1'b1, 3'd0, 245, 265);
        do_ev(300, 0, 0, 1'b0, 3'd1, 245, 265);
        do_ev(100, 0, 0, 1'b1, 3'd2, 340, 370);
        do_ev(100, 0, 0, 1'b0, 3'd3, 340, 370);
        do_ev(100, 50, 100, 1'b1, 3'd4, 245, 265);
        do_ev(100, 50, 100, 1'b0, 3'd5, 245, 265);
        t_irq();
        t_quiet();
        close_out();
    end
endmodule // testbench
